// ===== verilog/card_specific_data_fields.sv
`timescale 1ns/100ps
`include "card_data_params.svh"

module card_specific_data_fields (
    input  wire logic          clk,
    input  wire logic          reset,
    input  wire logic          ce,
    card_data_if.device        bus,
    input  wire logic [47:0]   head_fields,
    input  wire logic          access_check,
    input  wire logic          access_is_write,
    input  wire logic [31:0]   access_start,
    input  wire logic [11:0]   access_len,
    output logic [31:0]        capacity_bytes,
    output logic               access_done,
    output logic               access_ok,
    output logic               write_blocked,
    output logic [127:0]       card_image
);

    card_data_pkg::dev_state_t st_reg;
    card_data_pkg::dev_state_t st_next;

    logic [15:0]  low_prog;
    logic [127:0] image_now;
    logic [127:0] image_prog;
    logic [127:0] image_rst;
    logic [12:0]  read_max;
    logic [12:0]  offset_end;
    logic         read_fits;
    logic         write_fits;
    logic         locked;
    logic         prog_kept;
    logic [3:0]   read_exp;
    logic [2:0]   size_scale;
    logic [11:0]  device_size;
    logic [4:0]   capacity_shift;
    logic [31:0]  capacity_now;

    // =================================================================
    // Behaviour notes

    // The copy flag and the lifetime lock only ever rise while powered; a
    // reset returns them to their cleared defaults, so a system that needs
    // them to survive power loss must hold the image elsewhere.
    // The host's checksum is stored as sent; it is redone here only when a
    // kept one-time bit or bit 0 makes the stored word differ from the one
    // asked for, and at reset, so an answer never carries a stale checksum.
    // A low clock enable freezes every register unless reset is high, so an
    // answer arrives later by the number of frozen cycles and a check request seen only while frozen is dropped.

    // =================================================================
    // Image assembly

    // Builds the full register image from the fixed fields and a low half.
    function automatic logic [127:0] build(input logic [47:0] head,
                                           input logic [15:0] low);
        build = {head,
                 `CSD_PARTIAL_READ,
                 `CSD_WRITE_CROSS,
                 `CSD_READ_CROSS,
                 `CSD_DRIVER_STAGE,
                 `CSD_RSVD_76,
                 `CSD_DEVICE_SIZE,
                 `CSD_CURR_LOW_SUPPLY, `CSD_CURR_HIGH_SUP,
                 `CSD_CURR_LOW_SUPPLY, `CSD_CURR_HIGH_SUP,
                 `CSD_SIZE_SCALE,
                 `CSD_SECTOR_SIZE,
                 `CSD_ERASE_GROUP,
                 `CSD_PROTECT_CLUSTER, `CSD_PROTECT_ENABLE,
                 `CSD_DEFAULT_ECC,
                 `CSD_PROGRAM_FACTOR,
                 `CSD_WRITE_LEN_EXP,
                 `CSD_PARTIAL_WRITE,
                 `CSD_RSVD_20,
                 low};
    endfunction : build

    // Programmed low half: one-time bits only ever rise, bit 0 stays one.
    always_comb begin
        low_prog = bus.prog_data;
        low_prog[`CSD_COPY_BIT] = st_reg.low[`CSD_COPY_BIT]
                                | bus.prog_data[`CSD_COPY_BIT];
        low_prog[`CSD_LIFE_LOCK_BIT] = st_reg.low[`CSD_LIFE_LOCK_BIT]
                                     | bus.prog_data[`CSD_LIFE_LOCK_BIT];
        low_prog[0] = 1'b1;
    end

    // Current and programmed images; a kept one-time bit redoes the checksum.
    always_comb begin
        image_now  = build(head_fields, st_reg.low);
        prog_kept  = (low_prog != bus.prog_data);
        image_prog = build(head_fields, low_prog);
        if (prog_kept) begin
            image_prog[7:1] = card_data_pkg::crc7(image_prog);
        end
    end

    // Reset image: cleared low half, bit 0 set, and its own checksum.
    always_comb begin
        image_rst      = build(head_fields, {`CSD_LOW_RESET, 1'b1});
        image_rst[7:1] = card_data_pkg::crc7(image_rst);
    end

    // =================================================================
    // Capacity

    // Size terms taken apart so that the shift count cannot wrap.
    always_comb begin
        read_exp       = image_now[`CSD_READ_LEN_LSB +: 4];
        size_scale     = image_now[`CSD_SCALE_LSB +: 3];
        device_size    = image_now[`CSD_SIZE_LSB +: 12];
        capacity_shift = {2'h0, size_scale} + 5'h02 + {1'h0, read_exp};
        capacity_now   = ({20'h00000, device_size} + 32'h0000_0001)
                       << capacity_shift;
    end

    // =================================================================
    // Access legality

    // Limits derived from the length exponent and the physical block size.
    always_comb begin
        read_max   = 13'h0001 << read_exp;
        offset_end = {4'h0, access_start[8:0]} + {1'b0, access_len};
        locked     = st_reg.low[`CSD_LIFE_LOCK_BIT]
                   | st_reg.low[`CSD_TEMP_LOCK_BIT];
        read_fits  = (access_len != 12'h000)
                   && ({1'b0, access_len} <= read_max)
                   && (offset_end <= `CSD_BLOCK_BYTES);
        write_fits = ({1'b0, access_len} == `CSD_BLOCK_BYTES)
                   && (access_start[8:0] == 9'h000)
                   && !locked;
    end

    // =================================================================
    // Next state

    // Requests are taken on enabled edges and answered one cycle later.
    always_comb begin
        st_next = st_reg;
        st_next.resp_valid  = 1'b0;
        st_next.access_done = 1'b0;
        if (bus.prog_req) begin
            st_next.low          = image_prog[15:0];
            st_next.resp_valid   = 1'b1;
            st_next.resp_data    = image_prog;
            st_next.resp_ignored = prog_kept;
        end else if (bus.read_req) begin
            st_next.resp_valid   = 1'b1;
            st_next.resp_data    = image_now;
            st_next.resp_ignored = 1'b0;
        end
        if (access_check) begin
            st_next.access_done = 1'b1;
            st_next.access_ok   = access_is_write ? write_fits : read_fits;
        end
        st_next.blocked  = locked;
        st_next.capacity = capacity_now;
        if (reset) begin
            st_next              = '0;
            st_next.low          = image_rst[15:0];
            st_next.resp_data    = image_rst;
        end
    end

    // State register, frozen while the clock enable is low and reset is not high.
    always_ff @(posedge clk) begin
        if (reset || ce) begin
            st_reg <= st_next;
        end
    end

    // =================================================================
    // Outputs

    // All outputs come straight from the state register.
    assign bus.resp_valid   = st_reg.resp_valid;
    assign bus.resp_ignored = st_reg.resp_ignored;
    assign bus.resp_data    = st_reg.resp_data;
    assign capacity_bytes   = st_reg.capacity;
    assign access_done      = st_reg.access_done;
    assign access_ok        = st_reg.access_ok;
    assign write_blocked    = st_reg.blocked;
    assign card_image       = st_reg.resp_data;

endmodule : card_specific_data_fields

// ===== verilog/card_data_params.svh
`ifndef CARD_DATA_PARAMS_SVH
`define CARD_DATA_PARAMS_SVH

// =====================================================================
// Field positions inside the 128-bit card specific data image.
`define CSD_HEAD_LSB        80
`define CSD_READ_LEN_LSB    80
`define CSD_SIZE_LSB        62
`define CSD_SCALE_LSB       47
`define CSD_FMT_GRP_BIT     15
`define CSD_COPY_BIT        14
`define CSD_LIFE_LOCK_BIT   13
`define CSD_TEMP_LOCK_BIT   12
`define CSD_FORMAT_LSB      10
`define CSD_ECC_LSB         8
`define CSD_CRC_LSB         1

// =====================================================================
// Fixed field values reported by the card.
`define CSD_PARTIAL_READ    1'h1
`define CSD_WRITE_CROSS     1'h0
`define CSD_READ_CROSS      1'h0
`define CSD_DRIVER_STAGE    1'h0
`define CSD_RSVD_76         2'h0
`define CSD_DEVICE_SIZE     12'h7AB
`define CSD_CURR_LOW_SUPPLY 3'h5
`define CSD_CURR_HIGH_SUP   3'h4
`define CSD_SIZE_SCALE      3'h2
`define CSD_SECTOR_SIZE     5'h00
`define CSD_ERASE_GROUP     5'h0F
`define CSD_PROTECT_CLUSTER 5'h01
`define CSD_PROTECT_ENABLE  1'h1
`define CSD_DEFAULT_ECC     2'h0
`define CSD_PROGRAM_FACTOR  3'h2
`define CSD_WRITE_LEN_EXP   4'h9
`define CSD_PARTIAL_WRITE   1'h0
`define CSD_RSVD_20         5'h00

// =====================================================================
// Reset values and sizes.
`define CSD_LOW_RESET       15'h0000
`define CSD_BLOCK_BYTES     13'h0200
`define CSD_CRC_POLY        7'h09

`endif

// ===== verilog/card_data_pkg.sv
package card_data_pkg;

    // Host sequencer states.
    typedef enum logic [1:0] {
        HOST_IDLE = 2'b00,
        HOST_WAIT = 2'b01
    } host_state_t;

    // Device state, all held in one register.
    typedef struct packed {
        logic [15:0]  low;
        logic         resp_valid;
        logic         resp_ignored;
        logic [127:0] resp_data;
        logic [31:0]  capacity;
        logic         access_done;
        logic         access_ok;
        logic         blocked;
    } dev_state_t;

    // Host state, all held in one register.
    typedef struct packed {
        host_state_t  state;
        logic [127:0] image;
        logic         read_req;
        logic         prog_req;
        logic [15:0]  prog_data;
        logic         done;
        logic         ignored;
        logic         crc_error;
        logic         format_reserved;
        logic         ecc_reserved;
    } host_reg_t;

    // Seven-bit checksum of bits 127 down to 8, shifted in from the top.
    function automatic logic [6:0] crc7(input logic [127:0] image);
        logic [6:0] c;
        logic       fb;
        c = 7'h00;
        for (int i = 127; i >= 8; i--) begin
            fb = image[i] ^ c[6];
            c  = {c[5:0], 1'b0} ^ (fb ? 7'h09 : 7'h00);
        end
        return c;
    endfunction : crc7

endpackage : card_data_pkg

// ===== verilog/card_data_if.sv
`timescale 1ns/100ps

// =====================================================================
// Register access between host controller and card.
interface card_data_if;
    logic         read_req;
    logic         prog_req;
    logic [15:0]  prog_data;
    logic         resp_valid;
    logic         resp_ignored;
    logic [127:0] resp_data;

    modport device (
        input  read_req,
        input  prog_req,
        input  prog_data,
        output resp_valid,
        output resp_ignored,
        output resp_data
    );

    modport host (
        output read_req,
        output prog_req,
        output prog_data,
        input  resp_valid,
        input  resp_ignored,
        input  resp_data
    );
endinterface : card_data_if

// ===== verilog/card_data_host.sv
`timescale 1ns/100ps
`include "card_data_params.svh"

module card_data_host (
    input  wire logic          clk,
    input  wire logic          reset,
    input  wire logic          ce,
    card_data_if.host          bus,
    input  wire logic          user_read,
    input  wire logic          user_prog,
    input  wire logic [14:0]   user_fields,
    output logic               busy,
    output logic               done,
    output logic               ignored,
    output logic [127:0]       image,
    output logic               crc_error,
    output logic               format_reserved,
    output logic               ecc_reserved
);

    card_data_pkg::host_reg_t st_reg;
    card_data_pkg::host_reg_t st_next;

    logic [127:0] new_image;

    // =================================================================
    // Sequencer

    // Issues one request at a time and waits for the card's answer.
    always_comb begin
        new_image = st_reg.image;
        new_image[15:1] = user_fields;
        new_image[0] = 1'b1;
        new_image[7:1] = card_data_pkg::crc7(new_image);
        st_next = st_reg;
        st_next.read_req = 1'b0;
        st_next.prog_req = 1'b0;
        st_next.done     = 1'b0;
        case (st_reg.state)
            card_data_pkg::HOST_IDLE: begin
                if (user_prog) begin
                    st_next.prog_req  = 1'b1;
                    st_next.prog_data = new_image[15:0];
                    st_next.state     = card_data_pkg::HOST_WAIT;
                end else if (user_read) begin
                    st_next.read_req = 1'b1;
                    st_next.state    = card_data_pkg::HOST_WAIT;
                end
            end
            card_data_pkg::HOST_WAIT: begin
                if (bus.resp_valid) begin
                    st_next.image     = bus.resp_data;
                    st_next.ignored   = bus.resp_ignored;
                    st_next.done      = 1'b1;
                    st_next.state     = card_data_pkg::HOST_IDLE;
                    st_next.crc_error = card_data_pkg::crc7(bus.resp_data)
                                        != bus.resp_data[7:1];
                    st_next.format_reserved = bus.resp_data[`CSD_FMT_GRP_BIT];
                    st_next.ecc_reserved = bus.resp_data[`CSD_ECC_LSB +: 2]
                                           > 2'h1;
                end
            end
            default: begin
                st_next.state = card_data_pkg::HOST_IDLE;
            end
        endcase
        if (reset) begin
            st_next = '0;
        end
    end

    // State register, frozen while the clock enable is low and reset is not high.
    always_ff @(posedge clk) begin
        if (reset || ce) begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state register.
    assign bus.read_req    = st_reg.read_req;
    assign bus.prog_req    = st_reg.prog_req;
    assign bus.prog_data   = st_reg.prog_data;
    assign busy            = (st_reg.state != card_data_pkg::HOST_IDLE);
    assign done            = st_reg.done;
    assign ignored         = st_reg.ignored;
    assign image           = st_reg.image;
    assign crc_error       = st_reg.crc_error;
    assign format_reserved = st_reg.format_reserved;
    assign ecc_reserved    = st_reg.ecc_reserved;

endmodule : card_data_host

// ===== test/card_specific_data_fields_chk.sv
`timescale 1ns/100ps

// =====================================================================
// Field and protocol checks on the link between host and card.
module card_specific_data_fields_chk (
    input wire logic         clk,
    input wire logic         reset,
    input wire logic         read_req,
    input wire logic         prog_req,
    input wire logic [15:0]  prog_data,
    input wire logic         resp_valid,
    input wire logic         resp_ignored,
    input wire logic [127:0] resp_data
);
    logic copy_seen_reg;
    logic lock_seen_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // Remembers the one-time bits once an answer has shown them set.
    always_ff @(posedge clk) begin
        if (reset) begin
            copy_seen_reg <= 1'b0;
            lock_seen_reg <= 1'b0;
        end else if (resp_valid) begin
            copy_seen_reg <= copy_seen_reg | resp_data[14];
            lock_seen_reg <= lock_seen_reg | resp_data[13];
        end
    end

    // Independent checksum of bits 127 down to 8 for the answer check.
    function automatic logic [6:0] sum7(input logic [127:0] v);
        logic [6:0] c;
        c = 7'h00;
        for (int i = 127; i >= 8; i--) begin
            c = {c[5:0], 1'b0} ^ ((v[i] ^ c[6]) ? 7'h09 : 7'h00);
        end
        return c;
    endfunction : sum7

    AST_ANSWER: assert property (
        (read_req || prog_req) |=> resp_valid && resp_data[79])
        else $error("Answer missing or partial read bit wrong.");
    AST_NO_CROSS: assert property (
        resp_valid |-> resp_data[78:76] == 3'h0)
        else $error("Boundary or driver stage bits wrong.");
    AST_SIZE: assert property (
        resp_valid |-> resp_data[73:62] == 12'h7AB && resp_data[49:47] == 3'h2)
        else $error("Size fields wrong.");
    AST_CURRENT: assert property (
        resp_valid |-> resp_data[61:50] == {3'h5, 3'h4, 3'h5, 3'h4})
        else $error("Supply current codes wrong.");
    AST_GROUPS: assert property (
        resp_valid |-> resp_data[46:31] == {5'h00, 5'h0F, 5'h01, 1'h1})
        else $error("Erase or protect grouping wrong.");
    AST_WRITE_FIELDS: assert property (
        resp_valid |-> resp_data[30:21] == {2'h0, 3'h2, 4'h9, 1'h0})
        else $error("Write related fields wrong.");
    AST_COPY_KEPT: assert property (
        resp_valid && copy_seen_reg |-> resp_data[14])
        else $error("Copy flag was cleared.");
    AST_LOCK_KEPT: assert property (
        resp_valid && lock_seen_reg |-> resp_data[13])
        else $error("Lifetime lock was cleared.");
    AST_PROG_STORE: assert property (
        prog_req |=> resp_data[12:8] == $past(prog_data[12:8])
                     && (resp_ignored || resp_data[7:1] == $past(prog_data[7:1])))
        else $error("Programmed bits not stored.");
    AST_BIT0: assert property (
        resp_valid |-> resp_data[0])
        else $error("Bit zero not one.");
    AST_CRC: assert property (
        resp_valid |-> resp_data[7:1] == sum7(resp_data))
        else $error("Answer checksum wrong.");
    AST_IGNORED: assert property (
        prog_req && copy_seen_reg && !prog_data[14] |=> resp_ignored)
        else $error("Clearing copy flag not flagged.");
endmodule : card_specific_data_fields_chk

// ===== test/card_specific_data_fields_tb.sv
`timescale 1ns/100ps

`define CHECK(what, exp, got) begin checks_done++; if ((got) !== (exp)) begin errors++; \
    $display("MISMATCH %s expected %0h seen %0h", what, exp, got); end end

// =====================================================================
// Bench joining host and card through the shared link.
module card_specific_data_fields_tb;
    localparam logic [47:0] HEAD = 48'h4C0E_012A_0FF9;
    localparam logic [63:0] MID  = {4'h8, 2'h0, 12'h7AB, 3'h5, 3'h4, 3'h5, 3'h4, 3'h2,
                                    5'h00, 5'h0F, 5'h01, 1'h1, 2'h0, 3'h2, 4'h9, 1'h0, 5'h00};
    logic         clk, reset, ce, access_check, access_is_write, user_read, user_prog;
    logic [31:0]  access_start, capacity_bytes;
    logic [11:0]  access_len;
    logic [14:0]  user_fields;
    logic         access_done, access_ok, write_blocked, busy, done, ignored;
    logic         crc_error, format_reserved, ecc_reserved;
    logic [127:0] card_image, image;
    int           errors, checks_done, cycles;

    card_data_if card_bus ();

    card_specific_data_fields i_card_specific_data_fields (.clk(clk), .reset(reset), .ce(ce),
        .bus(card_bus), .head_fields(HEAD), .access_check(access_check),
        .access_is_write(access_is_write), .access_start(access_start),
        .access_len(access_len), .capacity_bytes(capacity_bytes), .access_done(access_done),
        .access_ok(access_ok), .write_blocked(write_blocked), .card_image(card_image));
    card_data_host i_card_data_host (.clk(clk), .reset(reset), .ce(ce), .bus(card_bus),
        .user_read(user_read), .user_prog(user_prog), .user_fields(user_fields),
        .busy(busy), .done(done), .ignored(ignored), .image(image), .crc_error(crc_error),
        .format_reserved(format_reserved), .ecc_reserved(ecc_reserved));
    card_specific_data_fields_chk i_chk (.clk(clk), .reset(reset),
        .read_req(card_bus.read_req), .prog_req(card_bus.prog_req),
        .prog_data(card_bus.prog_data), .resp_valid(card_bus.resp_valid),
        .resp_ignored(card_bus.resp_ignored), .resp_data(card_bus.resp_data));

    // Expected image with bits 15 to 8 given, bit 0 set and a freshly reckoned checksum.
    function automatic logic [127:0] exp_image(input logic [7:0] top);
        logic [127:0] v;
        logic [6:0]   c;
        logic         fb;
        v = {HEAD, MID, top, 8'h01};
        c = 7'h00;
        for (int i = 127; i >= 8; i--) begin
            fb = v[i] ^ c[6];
            c  = {c[5:0], 1'b0} ^ (fb ? 7'h09 : 7'h00);
        end
        v[7:1] = c;
        return v;
    endfunction : exp_image

    task automatic give_verdict;
        if (errors == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : give_verdict

    // One read or program through the host, then compare what came back.
    task automatic host_op(input logic prog, input logic [7:0] req, input logic [7:0] top,
                           input logic ign);
        int n;
        @(posedge clk);
        user_fields <= {req, 7'h00};
        user_prog   <= prog;
        user_read   <= !prog;
        @(posedge clk);
        user_prog <= 1'b0;
        user_read <= 1'b0;
        #1;
        `CHECK("host busy", 1'b1, busy)
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (done !== 1'b1 && n < 20);
        `CHECK("host done", 1'b1, done)
        `CHECK("host image", exp_image(top), image)
        `CHECK("crc error", 1'b0, crc_error)
        if (prog) `CHECK("ignored", ign, ignored)
    endtask : host_op

    // One access check with its expected verdict.
    task automatic acc(input logic w, input logic [31:0] start, input logic [11:0] len,
                       input logic ok);
        @(posedge clk);
        access_check    <= 1'b1;
        access_is_write <= w;
        access_start    <= start;
        access_len      <= len;
        @(posedge clk);
        access_check <= 1'b0;
        #1;
        `CHECK("access done", 1'b1, access_done)
        `CHECK("access ok", ok, access_ok)
    endtask : acc

    // Free running clock.
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Cuts a hang short.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            give_verdict;
        end
    end

    // Main sequence.
    initial begin
        reset = 1'b1;
        ce = 1'b1;
        access_check = 1'b0;
        access_is_write = 1'b0;
        access_start = 32'h0000_0000;
        access_len = 12'h000;
        user_read = 1'b0;
        user_prog = 1'b0;
        user_fields = 15'h0000;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        host_op(1'b0, 8'h00, 8'h00, 1'b0);
        `CHECK("card image", exp_image(8'h00), card_image)
        `CHECK("capacity", 32'h00F5_8000, capacity_bytes)
        host_op(1'b1, 8'h55, 8'h55, 1'b0);
        acc(1'b1, 32'h0000_0000, 12'h200, 1'b0);
        `CHECK("blocked", 1'b1, write_blocked)
        `CHECK("format reserved", 1'b0, format_reserved)
        `CHECK("ecc reserved", 1'b0, ecc_reserved)
        host_op(1'b1, 8'h8E, 8'hCE, 1'b1);
        `CHECK("format reserved", 1'b1, format_reserved)
        `CHECK("ecc reserved", 1'b1, ecc_reserved)
        `CHECK("blocked", 1'b0, write_blocked)
        acc(1'b0, 32'h0000_0000, 12'h001, 1'b1);
        acc(1'b0, 32'h0000_0000, 12'h200, 1'b1);
        acc(1'b0, 32'h0000_0000, 12'h201, 1'b0);
        acc(1'b0, 32'h0000_0000, 12'h000, 1'b0);
        acc(1'b0, 32'h0000_01FF, 12'h002, 1'b0);
        acc(1'b1, 32'h0000_0200, 12'h200, 1'b1);
        acc(1'b1, 32'h0000_0200, 12'h1FF, 1'b0);
        acc(1'b1, 32'h0000_0001, 12'h200, 1'b0);
        host_op(1'b1, 8'h60, 8'h60, 1'b0);
        acc(1'b1, 32'h0000_0000, 12'h200, 1'b0);
        host_op(1'b1, 8'h40, 8'h60, 1'b1);
        acc(1'b1, 32'h0000_0000, 12'h200, 1'b0);
        `CHECK("blocked", 1'b1, write_blocked)
        @(posedge clk);
        ce              <= 1'b0;
        access_check    <= 1'b1;
        access_is_write <= 1'b0;
        access_start    <= 32'h0000_0000;
        access_len      <= 12'h001;
        @(posedge clk);
        access_check <= 1'b0;
        #1;
        `CHECK("frozen done", 1'b0, access_done)
        `CHECK("frozen ok", 1'b0, access_ok)
        ce <= 1'b1;
        give_verdict;
    end
endmodule : card_specific_data_fields_tb
